// File: core_ops_pkg.sv
// Function
// - Plain return pops stack, two cycles, flags kept
// - Literal return loads W, pops stack, two cycles
// - Literal return takes PC from stack top
// - Left rotate through carry, only carry changes
// - Left rotate result to W or file
// - Right rotate through carry as ninth bit
// - Right rotate result to W or file
//
// Shared constants and types for the return and rotate execution core.
// Assumes a single clock domain and an external sequencer presenting one operation at a time.

package core_ops_pkg;

  // ----------------------------------------------------------------
  // Operation encoding
  // ----------------------------------------------------------------

  // Operations presented to the execution core.
  typedef enum logic [2:0]
  {
    op_nop,
    op_call,
    op_return,
    op_return_lit,
    op_rotate_left,
    op_rotate_right
  } op_type;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------

  // Destination select values for rotate results.
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Instruction cycles spent by returns and calls.
  localparam int unsigned RETURN_CYCLES = 2;

  // Values after reset.
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic [15:0] PC_RESET = 16'h0000;

endpackage

// File: carry_rotator.sv
// Combinational nine-bit rotate of a data byte through the carry flag.
// Assumes the caller registers the result; no state is held here.

`timescale 1ns/1ps

module carry_rotator
(
  // Operand
  input wire logic [7:0] data_in,
  input wire logic carry_in,
  input wire logic rotate_right,
  // Result
  output logic [7:0] data_out,
  output logic carry_out
);

  // ----------------------------------------------------------------
  // Rotate
  // ----------------------------------------------------------------

  // Carry enters the vacated end; the bit shifted out becomes the carry.
  always_comb
  begin
    if (rotate_right)
    begin
      data_out = {carry_in, data_in[7:1]};
      carry_out = data_in[0];
    end
    else
    begin
      data_out = {data_in[6:0], carry_in};
      carry_out = data_in[7];
    end
  end

endmodule

// File: return_rotate_core.sv
// Execution core for subroutine call, the two return forms and the two carry rotates.
// Assumes operations arrive synchronous to clk and are only taken while the core is not busy.

`timescale 1ns/1ps

module return_rotate_core
#(
  parameter int unsigned PC_W = 11,
  parameter int unsigned STACK_DEPTH = 16,
  parameter int unsigned FILE_AW = 7
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Operation request
  input wire logic op_valid,
  input wire core_ops_pkg::op_type op_code,
  input wire logic [7:0] op_literal,
  input wire logic [PC_W-1:0] op_target,
  input wire logic op_dest,
  input wire logic [FILE_AW-1:0] op_file,
  // Data memory preload and observation
  input wire logic load_en,
  input wire logic [FILE_AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic [FILE_AW-1:0] peek_addr,
  output logic [7:0] peek_data_q,
  // Core state
  output logic [PC_W-1:0] pc_q,
  output logic [7:0] working_register_q,
  output logic carry_q,
  output logic busy_q,
  output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr_q
);

  import core_ops_pkg::*;

  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------

  logic [PC_W-1:0] stack_mem [STACK_DEPTH]; // Return-address stack; pointer is next free slot.
  logic [7:0] file_mem [2**FILE_AW]; // Data memory addressed by the rotates.
  // Sequencer state: executing or spending the second cycle of a call or return.
  typedef enum logic {st_exec, st_flush} state_type;
  state_type state_q;
  logic take; // Operation accepted this cycle.
  logic [PC_W-1:0] stack_top; // Address popped by a return.
  logic [SP_W-1:0] sp_pop; // Pointer after a pop.
  logic [7:0] file_val; // Operand byte read from data memory.
  // Rotator result and carry.
  logic [7:0] rot_data;
  logic rot_carry;
  // Decoded operation classes.
  logic is_ret;
  logic is_rot;

  assign take = op_valid && (state_q == st_exec);
  assign sp_pop = stack_ptr_q - 1'b1;
  assign stack_top = stack_mem[sp_pop];
  assign file_val = file_mem[op_file];
  assign is_ret = (op_code == op_return) || (op_code == op_return_lit);
  assign is_rot = (op_code == op_rotate_left) || (op_code == op_rotate_right);

  // Shared rotate unit; direction follows the operation.
  carry_rotator u_rot
  (
    .data_in(file_val),
    .carry_in(carry_q),
    .rotate_right(op_code == op_rotate_right),
    .data_out(rot_data),
    .carry_out(rot_carry)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Calls and returns take a second, idle cycle while the fetch is redone.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= st_exec;
    end
    else
    begin
      case (state_q)
        st_exec:
        begin
          if (take && (is_ret || op_code == op_call))
          begin
            state_q <= st_flush;
          end
        end
        st_flush:
        begin
          state_q <= st_exec;
        end
        default:
        begin
          state_q <= st_exec;
        end
      endcase
    end
  end

  // Busy mirrors the second cycle so the requester holds off.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= take && (is_ret || op_code == op_call);
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack
  // ----------------------------------------------------------------

  // Returns load the popped address; calls jump; others step by one.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pc_q <= PC_RESET[PC_W-1:0];
    end
    else if (take)
    begin
      if (is_ret)
      begin
        pc_q <= stack_top;
      end
      else if (op_code == op_call)
      begin
        pc_q <= op_target;
      end
      else
      begin
        pc_q <= pc_q + 1'b1;
      end
    end
  end

  // Pointer wraps on overflow and underflow.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stack_ptr_q <= '0;
    end
    else if (take && is_ret)
    begin
      stack_ptr_q <= sp_pop;
    end
    else if (take && op_code == op_call)
    begin
      stack_ptr_q <= stack_ptr_q + 1'b1;
    end
  end

  // Stack contents are data, not control state, and are not reset.
  always_ff @(posedge clk)
  begin
    if (take && op_code == op_call)
    begin
      stack_mem[stack_ptr_q] <= pc_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Working register and carry
  // ----------------------------------------------------------------

  // Literal return loads the literal; a rotate to W loads the result.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      working_register_q <= WORK_RESET;
    end
    else if (take && op_code == op_return_lit)
    begin
      working_register_q <= op_literal;
    end
    else if (take && is_rot && op_dest == DEST_WORK)
    begin
      working_register_q <= rot_data;
    end
  end

  // Only rotates touch the carry; returns leave every flag alone.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      carry_q <= CARRY_RESET;
    end
    else if (take && is_rot)
    begin
      carry_q <= rot_carry;
    end
  end

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------

  // A rotate to the file wins over a preload in the same cycle.
  always_ff @(posedge clk)
  begin
    if (take && is_rot && op_dest == DEST_FILE)
    begin
      file_mem[op_file] <= rot_data;
    end
    else if (load_en)
    begin
      file_mem[load_addr] <= load_data;
    end
  end

  // Registered observation port.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      peek_data_q <= 8'h00;
    end
    else
    begin
      peek_data_q <= file_mem[peek_addr];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  // A return taken this cycle.
  sequence ret_taken_s;
    take && is_ret;
  endsequence

  // One busy cycle, then free again.
  sequence two_cycle_s;
    busy_q ##1 !busy_q;
  endsequence

  // Either return form lasts two cycles.
  ret_two_cycle_a: assert property (@(posedge clk) disable iff (!arst_n)
    ret_taken_s |=> two_cycle_s)
    else $error("return did not take two cycles");
  // Return loads the popped address.
  ret_pc_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && op_code == op_return) |=> pc_q == $past(stack_top) && stack_ptr_q == $past(sp_pop))
    else $error("return did not load stack top");
  // Literal return fills W and keeps carry.
  lit_work_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && op_code == op_return_lit) |=> working_register_q == $past(op_literal)
      && carry_q == $past(carry_q) ##1 !busy_q)
    else $error("literal return wrong W or carry");
  // Literal return takes the PC from the stack.
  lit_pc_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && op_code == op_return_lit) |=> pc_q == $past(stack_top))
    else $error("literal return wrong PC");
  // Left rotate carry comes from bit 7.
  left_carry_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && op_code == op_rotate_left) |=> carry_q == $past(file_val[7]) && !busy_q)
    else $error("left rotate carry wrong");
  // Left rotate result to W loads W.
  left_work_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && op_code == op_rotate_left && op_dest == DEST_WORK)
      |=> working_register_q == {$past(file_val[6:0]), $past(carry_q)})
    else $error("left rotate to W wrong");
  // Right rotate result and carry to W.
  right_work_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && op_code == op_rotate_right && op_dest == DEST_WORK)
      |=> working_register_q == {$past(carry_q), $past(file_val[7:1])}
      && carry_q == $past(file_val[0]))
    else $error("right rotate to W wrong");
  // Right rotate to file leaves W alone.
  right_file_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && op_code == op_rotate_right && op_dest == DEST_FILE)
      |=> working_register_q == $past(working_register_q)
      && file_mem[$past(op_file)] == {$past(carry_q), $past(file_val[7:1])})
    else $error("right rotate to file wrong");
  // Carry only changes on a rotate, so returns keep the flags.
  carry_only_rot_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(take && is_rot) |=> $stable(carry_q))
    else $error("carry changed outside a rotate");
endmodule

// File: return_and_rotate_instructions_tb.sv
// Self-checking testbench for the return and carry-rotate execution core.
// Assumes core_ops_pkg is compiled first; assertions live in the design files.

`timescale 1ns/1ps

module return_and_rotate_instructions_tb;
  import core_ops_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------

  // Program counter width used for the instance.
  localparam int unsigned PC_W = 11;
  logic clk;
  logic arst_n;
  logic op_valid;
  op_type op_code;
  logic [7:0] op_literal;
  logic [PC_W-1:0] op_target;
  logic op_dest;
  logic [6:0] op_file;
  logic load_en;
  logic [6:0] load_addr;
  logic [7:0] load_data;
  logic [6:0] peek_addr;
  logic [7:0] peek_data_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] working_register_q;
  logic carry_q;
  logic busy_q;
  logic [3:0] stack_ptr_q;
  // Expected core state, worked out from the operation semantics.
  logic [PC_W-1:0] exp_pc;
  logic [PC_W-1:0] saved_pc;
  logic [7:0] exp_w;
  logic exp_c;
  int errors;
  int comparisons;

  // Design under test.
  return_rotate_core #(.PC_W(PC_W), .STACK_DEPTH(16), .FILE_AW(7)) i_return_rotate_core
  (
    .clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
    .op_literal(op_literal), .op_target(op_target), .op_dest(op_dest), .op_file(op_file),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .peek_addr(peek_addr), .peek_data_q(peek_data_q), .pc_q(pc_q),
    .working_register_q(working_register_q), .carry_q(carry_q), .busy_q(busy_q),
    .stack_ptr_q(stack_ptr_q)
  );

  // Free-running 50 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Compare and driver tasks
  // ----------------------------------------------------------------

  // Compares a byte-wide result.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Compares a single flag.
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Compares the program counter.
  task automatic chk_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: pc got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Presents one operation at a falling edge; it is taken at the next rising edge.
  task automatic issue(input op_type code, input logic [7:0] lit, input logic [PC_W-1:0] tgt,
                       input logic dest, input logic [6:0] file);
    op_valid = 1'b1;
    op_code = code;
    op_literal = lit;
    op_target = tgt;
    op_dest = dest;
    op_file = file;
    @(posedge clk);
    @(negedge clk);
  endtask

  // Withdraws the request so that nothing more is taken.
  task automatic idle();
    op_valid = 1'b0;
  endtask

  // Writes one data memory byte through the preload port.
  task automatic preload(input logic [6:0] addr, input logic [7:0] data);
    load_en = 1'b1;
    load_addr = addr;
    load_data = data;
    @(posedge clk);
    @(negedge clk);
    load_en = 1'b0;
  endtask

  // Reads one data memory byte through the registered observation port.
  task automatic peek_check(input logic [6:0] addr, input logic [7:0] exp);
    peek_addr = addr;
    @(posedge clk);
    @(negedge clk);
    chk_byte(peek_data_q, exp, "file byte");
  endtask

  // Compares working register, carry and program counter with the expectation.
  task automatic chk_state();
    chk_byte(working_register_q, exp_w, "working register");
    chk_bit(carry_q, exp_c, "carry");
    chk_pc(pc_q, exp_pc);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------

  // Back-to-back left rotates to both destinations; the second file rotate
  // sees the byte written by the first.
  task automatic rotate_left_scn();
    preload(7'h05, 8'he6);
    issue(op_rotate_left, 8'h00, 11'h000, DEST_WORK, 7'h05);
    exp_pc = exp_pc + 1'b1;
    exp_w = 8'hcc;
    exp_c = 1'b1;
    chk_state();
    issue(op_rotate_left, 8'h00, 11'h000, DEST_FILE, 7'h05);
    exp_pc = exp_pc + 1'b1;
    chk_state();
    issue(op_rotate_left, 8'h00, 11'h000, DEST_FILE, 7'h05);
    idle();
    exp_pc = exp_pc + 1'b1;
    chk_state();
    peek_check(7'h05, 8'h9b);
  endtask

  // Right rotates to both destinations; the last one shifts a set bit 0
  // out so the carry comes back high, and must leave the file byte alone.
  task automatic rotate_right_scn();
    preload(7'h06, 8'h02);
    issue(op_rotate_right, 8'h00, 11'h000, DEST_WORK, 7'h06);
    exp_pc = exp_pc + 1'b1;
    exp_w = 8'h81;
    exp_c = 1'b0;
    chk_state();
    issue(op_rotate_right, 8'h00, 11'h000, DEST_FILE, 7'h06);
    exp_pc = exp_pc + 1'b1;
    chk_state();
    issue(op_rotate_right, 8'h00, 11'h000, DEST_WORK, 7'h06);
    idle();
    exp_pc = exp_pc + 1'b1;
    exp_w = 8'h00;
    exp_c = 1'b1;
    chk_state();
    peek_check(7'h06, 8'h01);
  endtask

  // A call followed by one return form; checks the pop, the flags and the two cycles.
  task automatic call_return_scn(input op_type code, input logic [7:0] lit,
                                 input logic [PC_W-1:0] tgt);
    issue(op_call, 8'h00, tgt, DEST_WORK, 7'h00);
    idle();
    saved_pc = exp_pc + 1'b1;
    exp_pc = tgt;
    chk_pc(pc_q, exp_pc);
    chk_byte({4'h0, stack_ptr_q}, 8'h01, "stack pointer after call");
    @(negedge clk);
    issue(code, lit, 11'h000, DEST_WORK, 7'h00);
    idle();
    exp_pc = saved_pc;
    if (code == op_return_lit)
      exp_w = lit;
    chk_state();
    chk_bit(busy_q, 1'b1, "busy in second cycle");
    chk_byte({4'h0, stack_ptr_q}, 8'h00, "stack pointer after return");
    @(negedge clk);
    chk_bit(busy_q, 1'b0, "busy after two cycles");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------

  // Resets the core, checks reset values, then runs every scenario.
  initial
  begin
    errors = 0;
    comparisons = 0;
    arst_n = 1'b0;
    op_valid = 1'b0;
    op_code = op_nop;
    op_literal = 8'h00;
    op_target = 11'h000;
    op_dest = DEST_WORK;
    op_file = 7'h00;
    load_en = 1'b0;
    load_addr = 7'h00;
    load_data = 8'h00;
    peek_addr = 7'h00;
    exp_pc = 11'h000;
    exp_w = WORK_RESET;
    exp_c = CARRY_RESET;
    repeat (16) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    chk_state();
    chk_bit(busy_q, 1'b0, "busy after reset");
    issue(op_nop, 8'h00, 11'h000, DEST_WORK, 7'h00);
    idle();
    exp_pc = exp_pc + 1'b1;
    chk_state();
    rotate_left_scn();
    rotate_right_scn();
    call_return_scn(op_return_lit, 8'ha5, 11'h123);
    issue(op_rotate_left, 8'h00, 11'h000, DEST_WORK, 7'h05);
    idle();
    exp_pc = exp_pc + 1'b1;
    exp_w = 8'h37;
    exp_c = 1'b1;
    chk_state();
    call_return_scn(op_return, 8'h5a, 11'h055);
    give_verdict();
  end

  // Cuts a hung run short and reports it as a mismatch.
  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    give_verdict();
  end

endmodule
